// ===== core/dcs_pkg.sv
package dcs_pkg;

  // ==========================================================
  // widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CODE_W = 12;
  localparam int unsigned HZ_W   = 7;
  localparam int unsigned SEC_W  = 8;
  localparam int unsigned PROD_W = 20;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MINF   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ACCEL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DECEL  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // ==========================================================
  // control register fields
  localparam int unsigned CTRL_SCHEME_LSB = 0;
  localparam int unsigned CTRL_SCHEME_W   = 4;
  localparam int unsigned CTRL_MANUAL_BIT = 4;
  localparam int unsigned CTRL_KEYRUN_BIT = 5;
  localparam int unsigned CTRL_COAST_BIT  = 6;

  // ==========================================================
  // status register fields
  localparam int unsigned ST_RUN_BIT      = 0;
  localparam int unsigned ST_PFAIL_BIT    = 1;
  localparam int unsigned ST_BFAIL_BIT    = 2;
  localparam int unsigned ST_BACKUP_BIT   = 3;
  localparam int unsigned ST_INVALID_BIT  = 4;
  localparam int unsigned ST_FAILOVER_BIT = 5;
  localparam int unsigned ST_MODE_LSB     = 8;
  localparam int unsigned ST_SETPT_LSB    = 12;
  localparam int unsigned ST_HOA_LSB      = 14;

  // ==========================================================
  // reset values and limits
  localparam logic [CTRL_SCHEME_W-1:0] SCHEME_RST = 4'h0;
  localparam logic [CTRL_SCHEME_W-1:0] SCHEME_MAX = 4'h8;
  localparam logic [HZ_W-1:0]          MINF_RST   = 7'h1E;
  localparam logic [HZ_W-1:0]          MINF_FLOOR = 7'h05;
  localparam logic [HZ_W-1:0]          MAXF_HZ    = 7'h3C;
  localparam logic [SEC_W-1:0]         ACCEL_RST  = 8'h0C;
  localparam logic [SEC_W-1:0]         DECEL_RST  = 8'h0C;

  // ==========================================================
  // analog code levels
  localparam logic [CODE_W-1:0] LOOP_LO_CODE = 12'h02AB;
  localparam logic [CODE_W-1:0] LOOP_HI_CODE = 12'h0D55;
  localparam logic [CODE_W-1:0] FAIL_LO_CODE = 12'h0255;
  localparam logic [CODE_W-1:0] FAIL_HI_CODE = 12'h0E00;
  localparam logic [CODE_W-1:0] VOLT_FULL    = 12'h0FFF;

  // ==========================================================
  // scheme codes
  localparam logic [CTRL_SCHEME_W-1:0] SCH_ONOFF   = 4'h0;
  localparam logic [CTRL_SCHEME_W-1:0] SCH_CP      = 4'h1;
  localparam logic [CTRL_SCHEME_W-1:0] SCH_CP_RED2 = 4'h2;
  localparam logic [CTRL_SCHEME_W-1:0] SCH_CP_RED4 = 4'h3;
  localparam logic [CTRL_SCHEME_W-1:0] SCH_SPD_I1  = 4'h4;
  localparam logic [CTRL_SCHEME_W-1:0] SCH_SPD_I2  = 4'h5;
  localparam logic [CTRL_SCHEME_W-1:0] SCH_SPD_POT = 4'h6;
  localparam logic [CTRL_SCHEME_W-1:0] SCH_HOA     = 4'h7;
  localparam logic [CTRL_SCHEME_W-1:0] SCH_SWAP    = 4'h8;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    MODE_HOLD  = 4'b0001,
    MODE_ONOFF = 4'b0010,
    MODE_CP    = 4'b0100,
    MODE_SPEED = 4'b1000
  } dcs_mode_t;

  typedef enum logic [1:0] {
    SRC_PRIMARY = 2'b00,
    SRC_BACKUP  = 2'b01,
    SRC_VOLTAGE = 2'b10
  } dcs_src_t;

  typedef enum logic [1:0] {
    HOA_OFF  = 2'b00,
    HOA_HAND = 2'b01,
    HOA_AUTO = 2'b10
  } dcs_hoa_t;

  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } dcs_contacts_t;

  typedef struct packed {
    logic       coast;
    logic       key_run;
    logic       manual;
    logic [3:0] scheme;
  } dcs_ctrl_t;

endpackage : dcs_pkg

// ===== core/dcs_top.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module dcs_top
  import dcs_pkg::*;
#(
  parameter logic [HZ_W-1:0] MAX_HZ = MAXF_HZ
) (
  // apb clock, reset, enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  // apb slave
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [DATA_W-1:0]    pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output logic [DATA_W-1:0]         prdata,
  output logic                      pslverr,
  // field contacts and analog codes
  input  wire dcs_contacts_t        field_contacts,
  input  wire logic [CODE_W-1:0]    primary_current_input,
  input  wire logic [CODE_W-1:0]    backup_current_input,
  input  wire logic [CODE_W-1:0]    voltage_input,
  // drive commands
  output logic                      run_cmd,
  output dcs_mode_t                 ctl_mode,
  output dcs_src_t                  feedback_src,
  output logic [1:0]                setpoint_idx,
  output logic [CODE_W-1:0]         speed_ref,
  output logic                      precharge_leadlag_en,
  output logic [SEC_W-1:0]          acceleration_ramp_duration,
  output logic [SEC_W-1:0]          decel_ramp_duration,
  output logic                      decel_ramp_en,
  output dcs_hoa_t                  hand_off_auto_switch,
  output logic                      primary_fail,
  output logic                      backup_fail,
  output logic                      failover_event
);

  // ==========================================================
  // contact synchronisers
  dcs_contacts_t meta_q;
  dcs_contacts_t cts_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      cts_q  <= '0;
    end else if (ce) begin
      meta_q <= field_contacts;
      cts_q  <= meta_q;
    end
  end

  // ==========================================================
  // registers
  dcs_ctrl_t         ctrl_q;
  logic [HZ_W-1:0]   minf_q;
  logic [SEC_W-1:0]  accel_q;
  logic [SEC_W-1:0]  decel_q;
  logic              failover_sticky_q;
  logic              backup_sel_q;

  logic setup_ph;
  logic wr_acc;
  logic hit;
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pready & pwrite & pstrb[0];

  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_MINF, OFS_ACCEL, OFS_DECEL, OFS_STATUS: hit = 1'b1;
      default:                                            hit = 1'b0;
    endcase
  end

  // ceiling at MAX_HZ keeps a full-range analog reference possible
  logic [HZ_W-1:0] minf_wr;
  always_comb begin
    minf_wr = pwdata[HZ_W-1:0];
    if (minf_wr < MINF_FLOOR) begin
      minf_wr = MINF_FLOOR;
    end else if (minf_wr > MAX_HZ) begin
      minf_wr = MAX_HZ;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '{coast: 1'b0, key_run: 1'b0, manual: 1'b0, scheme: SCHEME_RST};
    end else if (ce && wr_acc && paddr == OFS_CTRL) begin
      ctrl_q.scheme  <= pwdata[CTRL_SCHEME_LSB +: CTRL_SCHEME_W];
      ctrl_q.manual  <= pwdata[CTRL_MANUAL_BIT];
      ctrl_q.key_run <= pwdata[CTRL_KEYRUN_BIT];
      ctrl_q.coast   <= pwdata[CTRL_COAST_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      minf_q  <= MINF_RST;
      accel_q <= ACCEL_RST;
      decel_q <= DECEL_RST;
    end else if (ce && wr_acc) begin
      if (paddr == OFS_MINF) begin
        minf_q <= minf_wr;
      end
      if (paddr == OFS_ACCEL) begin
        accel_q <= pwdata[SEC_W-1:0];
      end
      if (paddr == OFS_DECEL) begin
        decel_q <= pwdata[SEC_W-1:0];
      end
    end
  end

  // ==========================================================
  // sensor health and selection
  logic       p_bad;
  logic       b_bad;
  logic       sch_invalid;
  logic       redundant;
  logic       backup_sel_d;
  logic       fo_ev;
  assign p_bad       = (primary_current_input < FAIL_LO_CODE) | (primary_current_input > FAIL_HI_CODE);
  assign b_bad       = (backup_current_input < FAIL_LO_CODE) | (backup_current_input > FAIL_HI_CODE);
  assign sch_invalid = ctrl_q.scheme > SCHEME_MAX;
  assign redundant   = (ctrl_q.scheme == SCH_CP_RED2) | (ctrl_q.scheme == SCH_CP_RED4)
                     | (ctrl_q.scheme == SCH_SWAP);

  always_comb begin
    backup_sel_d = 1'b0;
    if (redundant && p_bad) begin
      backup_sel_d = 1'b1;
    end
    if (ctrl_q.scheme == SCH_SWAP && cts_q.c) begin
      backup_sel_d = 1'b1;
    end
  end

  // event only when health, not the swap contact, moved the loop
  assign fo_ev = backup_sel_d & ~backup_sel_q & redundant & p_bad;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backup_sel_q <= 1'b0;
    end else if (ce) begin
      backup_sel_q <= backup_sel_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      failover_sticky_q <= 1'b0;
    end else if (ce) begin
      if (fo_ev) begin
        failover_sticky_q <= 1'b1;
      end else if (wr_acc && paddr == OFS_STATUS && pwdata[ST_FAILOVER_BIT]) begin
        failover_sticky_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // scheme decode
  dcs_mode_t  mode_d;
  dcs_src_t   src_d;
  logic       auto_run;
  logic [1:0] setpt_d;
  logic       cp_scheme;

  always_comb begin
    mode_d    = MODE_HOLD;
    src_d     = SRC_PRIMARY;
    auto_run  = 1'b0;
    setpt_d   = 2'b00;
    cp_scheme = 1'b0;
    unique case (ctrl_q.scheme)
      SCH_ONOFF: begin
        mode_d   = MODE_ONOFF;
        auto_run = cts_q.a & cts_q.b;
      end
      SCH_CP: begin
        mode_d    = MODE_CP;
        cp_scheme = 1'b1;
        auto_run  = cts_q.a & cts_q.b & ~p_bad;
      end
      SCH_CP_RED2: begin
        mode_d    = MODE_CP;
        cp_scheme = 1'b1;
        src_d     = backup_sel_q ? SRC_BACKUP : SRC_PRIMARY;
        setpt_d   = {1'b0, cts_q.c};
        auto_run  = cts_q.a & cts_q.b & ~(p_bad & b_bad);
      end
      SCH_CP_RED4: begin
        mode_d    = MODE_CP;
        cp_scheme = 1'b1;
        src_d     = backup_sel_q ? SRC_BACKUP : SRC_PRIMARY;
        setpt_d   = {cts_q.d, cts_q.c};
        auto_run  = cts_q.a & cts_q.b & ~(p_bad & b_bad);
      end
      SCH_SPD_I1: begin
        mode_d   = MODE_SPEED;
        src_d    = SRC_PRIMARY;
        auto_run = cts_q.a & cts_q.b;
      end
      SCH_SPD_I2: begin
        mode_d   = MODE_SPEED;
        src_d    = SRC_BACKUP;
        auto_run = cts_q.a & cts_q.b;
      end
      SCH_SPD_POT: begin
        mode_d   = MODE_SPEED;
        src_d    = SRC_VOLTAGE;
        auto_run = cts_q.a & cts_q.b;
      end
      SCH_HOA: begin
        cp_scheme = 1'b1;
        if (cts_q.c) begin
          mode_d   = MODE_SPEED;
          src_d    = SRC_VOLTAGE;
          auto_run = cts_q.a;
        end else begin
          mode_d   = MODE_CP;
          auto_run = cts_q.a & cts_q.b & ~p_bad;
        end
      end
      SCH_SWAP: begin
        mode_d    = MODE_CP;
        cp_scheme = 1'b1;
        src_d     = backup_sel_q ? SRC_BACKUP : SRC_PRIMARY;
        auto_run  = cts_q.a & cts_q.b & ~(p_bad & b_bad);
      end
      default: begin
        mode_d   = MODE_HOLD;
        auto_run = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // speed reference with minimum-frequency gate
  logic [CODE_W-1:0] raw_code;
  logic [CODE_W-1:0] norm;
  logic [CODE_W-1:0] span;
  logic [PROD_W-1:0] lhs;
  logic [PROD_W-1:0] rhs;
  logic              above_min;

  always_comb begin
    unique case (src_d)
      SRC_BACKUP:  raw_code = backup_current_input;
      SRC_VOLTAGE: raw_code = voltage_input;
      default:     raw_code = primary_current_input;
    endcase
    if (src_d == SRC_VOLTAGE) begin
      norm = raw_code;
      span = VOLT_FULL;
    end else begin
      norm = (raw_code > LOOP_LO_CODE) ? CODE_W'(raw_code - LOOP_LO_CODE) : '0;
      span = CODE_W'(LOOP_HI_CODE - LOOP_LO_CODE);
      if (norm > span) begin
        norm = span;
      end
    end
  end

  // cross-multiplied to avoid a divider
  assign lhs       = PROD_W'(norm) * PROD_W'(MAX_HZ);
  assign rhs       = PROD_W'(minf_q) * PROD_W'(span);
  assign above_min = lhs >= rhs;

  // ==========================================================
  // outputs
  logic run_d;
  always_comb begin
    if (ctrl_q.manual) begin
      run_d = ctrl_q.key_run;
    end else if (mode_d == MODE_SPEED) begin
      run_d = auto_run & above_min;
    end else begin
      run_d = auto_run;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cmd      <= 1'b0;
      ctl_mode     <= MODE_ONOFF;
      feedback_src <= SRC_PRIMARY;
      setpoint_idx <= 2'b00;
      speed_ref    <= '0;
    end else if (ce) begin
      run_cmd      <= run_d;
      ctl_mode     <= mode_d;
      feedback_src <= src_d;
      setpoint_idx <= setpt_d;
      speed_ref    <= (mode_d == MODE_SPEED && above_min) ? norm : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      precharge_leadlag_en       <= 1'b0;
      acceleration_ramp_duration <= ACCEL_RST;
      decel_ramp_duration        <= '0;
      decel_ramp_en              <= 1'b0;
    end else if (ce) begin
      precharge_leadlag_en       <= cp_scheme & ~sch_invalid;
      acceleration_ramp_duration <= accel_q;
      decel_ramp_en              <= ctrl_q.coast;
      decel_ramp_duration        <= ctrl_q.coast ? decel_q : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hand_off_auto_switch <= HOA_OFF;
      primary_fail         <= 1'b0;
      backup_fail          <= 1'b0;
      failover_event       <= 1'b0;
    end else if (ce) begin
      hand_off_auto_switch <= !cts_q.a ? HOA_OFF : (cts_q.c ? HOA_HAND : HOA_AUTO);
      primary_fail         <= p_bad;
      backup_fail          <= b_bad;
      failover_event       <= fo_ev;
    end
  end

  // ==========================================================
  // apb read path, one access cycle, no wait states
  logic [DATA_W-1:0] rd_d;
  always_comb begin
    rd_d = '0;
    unique case (paddr)
      OFS_CTRL: begin
        rd_d[CTRL_SCHEME_LSB +: CTRL_SCHEME_W] = ctrl_q.scheme;
        rd_d[CTRL_MANUAL_BIT]                  = ctrl_q.manual;
        rd_d[CTRL_KEYRUN_BIT]                  = ctrl_q.key_run;
        rd_d[CTRL_COAST_BIT]                   = ctrl_q.coast;
      end
      OFS_MINF:  rd_d[HZ_W-1:0]  = minf_q;
      OFS_ACCEL: rd_d[SEC_W-1:0] = accel_q;
      OFS_DECEL: rd_d[SEC_W-1:0] = decel_q;
      OFS_STATUS: begin
        rd_d[ST_RUN_BIT]         = run_cmd;
        rd_d[ST_PFAIL_BIT]       = primary_fail;
        rd_d[ST_BFAIL_BIT]       = backup_fail;
        rd_d[ST_BACKUP_BIT]      = backup_sel_q;
        rd_d[ST_INVALID_BIT]     = sch_invalid;
        rd_d[ST_FAILOVER_BIT]    = failover_sticky_q;
        rd_d[ST_MODE_LSB +: 4]   = ctl_mode;
        rd_d[ST_SETPT_LSB +: 2]  = setpoint_idx;
        rd_d[ST_HOA_LSB +: 2]    = hand_off_auto_switch;
      end
      default: rd_d = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup_ph;
      if (setup_ph) begin
        prdata  <= pwrite ? '0 : rd_d;
        pslverr <= ~hit;
      end
    end
  end

endmodule : dcs_top

// ===== bench/dcs_top_asserts.sv
`timescale 1ns/1ps
module dcs_top_asserts
  import dcs_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb request
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  // field side
  input wire dcs_contacts_t     field_contacts,
  input wire logic [CODE_W-1:0] primary_current_input,
  // drive commands
  input wire logic              run_cmd,
  input wire dcs_mode_t         ctl_mode,
  input wire dcs_src_t          feedback_src,
  input wire logic [CODE_W-1:0] speed_ref,
  input wire logic              precharge_leadlag_en,
  input wire logic [SEC_W-1:0]  acceleration_ramp_duration,
  input wire logic [SEC_W-1:0]  decel_ramp_duration,
  input wire logic              decel_ramp_en,
  input wire dcs_hoa_t          hand_off_auto_switch,
  input wire logic              primary_fail,
  input wire logic              failover_event
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========
  // helpers
  logic wr_accel;
  assign wr_accel = psel && penable && pwrite && (paddr == OFS_ACCEL);

  // two quiet cycles also cover a ramp output one cycle behind its register
  sequence s_quiet;
    !wr_accel ##1 !wr_accel;
  endsequence
  sequence s_switch;
    primary_fail ##1 (!failover_event && feedback_src == SRC_BACKUP);
  endsequence

  // ==========
  // checks
  chk_accel_hold: assert property (s_quiet |=> $stable(acceleration_ramp_duration))
    else $error("ramp moved without a write");
  chk_decel_off: assert property (!decel_ramp_en |-> decel_ramp_duration == '0)
    else $error("shutdown ramp active while disabled");
  chk_hold_stop: assert property (ctl_mode == MODE_HOLD |-> !run_cmd)
    else $error("motor runs on invalid scheme");
  chk_precharge_gate: assert property (ctl_mode inside {MODE_HOLD, MODE_ONOFF} |-> !precharge_leadlag_en)
    else $error("precharge outside pressure scheme");
  chk_speed_zero: assert property (ctl_mode != MODE_SPEED |-> speed_ref == '0)
    else $error("speed reference outside speed mode");
  chk_loop_valid: assert property ((primary_current_input >= LOOP_LO_CODE
    && primary_current_input <= LOOP_HI_CODE) |=> !primary_fail)
    else $error("sensor flagged inside window");
  chk_failover_seq: assert property (failover_event |-> s_switch)
    else $error("failover event without switch");
  chk_hoa_off: assert property (!$past(field_contacts.a, 3) |-> hand_off_auto_switch == HOA_OFF)
    else $error("switch not off with contact open");
endmodule : dcs_top_asserts

bind dcs_top dcs_top_asserts i_dcs_top_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .field_contacts, .primary_current_input, .run_cmd,
  .ctl_mode, .feedback_src, .speed_ref, .precharge_leadlag_en, .acceleration_ramp_duration,
  .decel_ramp_duration, .decel_ramp_en, .hand_off_auto_switch, .primary_fail, .failover_event
);

// ===== bench/dcs_field_model.sv
`timescale 1ns/1ps
module dcs_field_model
  import dcs_pkg::*;
(
  // bench requests
  input wire logic              pclk,
  input wire logic [3:0]        close_req,
  input wire logic [CODE_W-1:0] pri_req,
  input wire logic [CODE_W-1:0] bak_req,
  input wire logic [CODE_W-1:0] pot_req,
  // field terminals
  output dcs_contacts_t         field_contacts,
  output logic [CODE_W-1:0]     primary_current_input,
  output logic [CODE_W-1:0]     backup_current_input,
  output logic [CODE_W-1:0]     voltage_input
);
  logic [3:0] prev_q;
  logic [3:0] prev2_q;

  // ==========
  // contacts bounce back once after each change; a broken loop reads code 0
  initial begin
    prev_q = '0;
    prev2_q = '0;
    field_contacts = '0;
  end
  always @(posedge pclk) begin
    prev_q <= close_req;
    prev2_q <= prev_q;
    field_contacts <= dcs_contacts_t'((close_req == prev_q && prev_q != prev2_q) ? prev2_q : close_req);
    primary_current_input <= pri_req;
    backup_current_input <= bak_req;
    voltage_input <= pot_req;
  end
endmodule : dcs_field_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
  import dcs_pkg::*;

  // ==========
  // wiring
  logic              pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0]        pstrb, close_req;
  logic [CODE_W-1:0] pri_req, bak_req, pot_req, speed_ref, code;
  logic [CODE_W-1:0] primary_current_input, backup_current_input, voltage_input;
  logic              run_cmd, precharge_leadlag_en, decel_ramp_en, primary_fail, backup_fail, failover_event;
  logic [1:0]        setpoint_idx;
  logic [SEC_W-1:0]  acceleration_ramp_duration, decel_ramp_duration;
  logic [31:0]       rng;
  dcs_contacts_t     field_contacts;
  dcs_mode_t         ctl_mode;
  dcs_src_t          feedback_src;
  dcs_hoa_t          hand_off_auto_switch;
  int                n_mismatch, samples_checked, n_fo, fo0, minf;
  localparam logic [3:0] S7_SET [4] = '{4'h0, 4'h5, 4'h1, 4'h3};

  dcs_top i_dcs_top (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .pready, .prdata,
    .pslverr, .field_contacts, .primary_current_input, .backup_current_input, .voltage_input, .run_cmd,
    .ctl_mode, .feedback_src, .setpoint_idx, .speed_ref, .precharge_leadlag_en, .acceleration_ramp_duration,
    .decel_ramp_duration, .decel_ramp_en, .hand_off_auto_switch, .primary_fail, .backup_fail, .failover_event);
  dcs_field_model i_dcs_field_model (.pclk, .close_req, .pri_req, .bak_req, .pot_req, .field_contacts,
    .primary_current_input, .backup_current_input, .voltage_input);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (failover_event === 1'b1) n_fo <= n_fo + 1;

  // ==========
  // helpers
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic logic [CODE_W-1:0] exp_spd(input logic [CODE_W-1:0] c, input logic volt);
    int lo, span;
    lo = volt ? 0 : int'(LOOP_LO_CODE);
    span = volt ? int'(VOLT_FULL) : int'(LOOP_HI_CODE - LOOP_LO_CODE);
    return ((int'(c) - lo) * int'(MAXF_HZ) >= minf * span) ? CODE_W'(int'(c) - lo) : '0;
  endfunction : exp_spd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] adr, input logic [DATA_W-1:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask : settle

  task automatic fld(input logic [3:0] c, input logic [CODE_W-1:0] p = 12'h0800, b = 12'h0800, v = 12'h0000);
    close_req <= c;
    pri_req <= p;
    bak_req <= b;
    pot_req <= v;
    settle();
  endtask : fld

  task automatic scheme(input logic [3:0] s);
    apb(1'b1, OFS_CTRL, 32'(s));
    settle();
  endtask : scheme

  // ==========
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    close_out();
  end

  // ==========
  // main sequence
  initial begin
    rng = 32'd99;
    {ce, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = {1'b1, 1'b0, 3'b000, 8'h00, 32'h0000_0000, 4'hf};
    {close_req, pri_req, bak_req, pot_req, minf} = {4'h0, 12'h0800, 12'h0800, 12'h0000, 32'd30};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk(32'(ctl_mode), 32'(MODE_ONOFF));
    chk(32'(acceleration_ramp_duration), 32'h0000_000C);
    chk(32'({decel_ramp_en, decel_ramp_duration}), 32'h0000_0000);
    apb(1'b0, OFS_CTRL, '0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, OFS_ACCEL, '0);
    chk(rd, 32'h0000_000C);
    // second write has no byte-0 strobe and must be dropped
    apb(1'b1, OFS_ACCEL, 32'h0000_0014);
    pstrb <= 4'h0;
    apb(1'b1, OFS_ACCEL, 32'h0000_0033);
    pstrb <= 4'hf;
    settle();
    chk(32'(acceleration_ramp_duration), 32'h0000_0014);
    apb(1'b0, 8'h14, '0);
    chk(32'({err, rd[30:0]}), 32'h8000_0000);
    apb(1'b1, OFS_MINF, 32'h0000_0002);
    apb(1'b0, OFS_MINF, '0);
    chk(rd, 32'h0000_0005);
    apb(1'b1, OFS_MINF, 32'h0000_001E);
    for (int i = 0; i < 4; i++) begin
      fld(4'(i));
      chk(32'(run_cmd), 32'(i == 3));
    end
    chk(32'(precharge_leadlag_en), 32'h0000_0000);
    for (int s = 2; s < 4; s++) begin
      scheme(4'(s));
      for (int i = 0; i < 4; i++) begin
        fld(4'(4 * i + 3));
        chk(32'(setpoint_idx), (s == 2) ? (i & 1) : i);
        chk(32'({ctl_mode, run_cmd, precharge_leadlag_en}), 32'({MODE_CP, 2'b11}));
      end
    end
    scheme(SCH_CP);
    fld(4'h3);
    chk(32'({ctl_mode, feedback_src, run_cmd}), 32'({MODE_CP, SRC_PRIMARY, 1'b1}));
    // random references, with full scale as the corner
    for (int s = 4; s < 7; s++) begin
      scheme(4'(s));
      for (int k = 0; k < 4; k++) begin
        if (k == 0) code = (s == 6) ? VOLT_FULL : LOOP_HI_CODE;
        else if (s == 6) code = 12'(xs());
        else code = LOOP_LO_CODE + 12'(xs() % 2731);
        fld(4'h3, (s == 4) ? code : 12'h0800, (s == 5) ? code : 12'h0800, (s == 6) ? code : 12'h0000);
        chk(32'(speed_ref), 32'(exp_spd(code, s == 6)));
        chk(32'(feedback_src), 32'(s - 4));
        if (k == 0) chk(32'(run_cmd), 32'h0000_0001);
      end
      fld(4'h1);
      chk(32'({run_cmd, precharge_leadlag_en}), 32'h0000_0000);
    end
    apb(1'b1, OFS_MINF, 32'h0000_0005);
    minf = 5;
    fld(4'h3, 12'h0800, 12'h0800, 12'h0200);
    chk(32'(speed_ref), 32'(exp_spd(12'h0200, 1'b1)));
    apb(1'b1, OFS_MINF, 32'h0000_001E);
    minf = 30;
    scheme(SCH_HOA);
    foreach (S7_SET[i]) begin
      fld(S7_SET[i], 12'h0800, 12'h0800, VOLT_FULL);
      chk(32'(run_cmd), 32'(S7_SET[i][0] & (S7_SET[i][1] | S7_SET[i][2])));
      chk(32'(hand_off_auto_switch), !S7_SET[i][0] ? 0 : S7_SET[i][2] ? 1 : 2);
      if (i > 0) chk(32'(ctl_mode), 32'(S7_SET[i][2] ? MODE_SPEED : MODE_CP));
    end
    for (int s = 9; s < 16; s += 3) begin
      scheme(4'(s));
      chk(32'({ctl_mode, run_cmd, precharge_leadlag_en}), 32'({MODE_HOLD, 2'b00}));
    end
    apb(1'b0, OFS_STATUS, '0);
    chk(32'(rd[4]), 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_0030);
    fld(4'h0);
    chk(32'(run_cmd), 32'h0000_0001);
    apb(1'b1, OFS_CTRL, 32'h0000_0040);
    settle();
    chk(32'({decel_ramp_en, decel_ramp_duration}), 32'h0000_010C);
    // primary loop breaks while running
    scheme(SCH_CP_RED2);
    fld(4'h3);
    fo0 = n_fo;
    fld(4'h3, 12'h0000);
    chk(32'({primary_fail, feedback_src, run_cmd}), 32'({1'b1, SRC_BACKUP, 1'b1}));
    chk(n_fo - fo0, 1);
    apb(1'b0, OFS_STATUS, '0);
    chk(32'(rd[5:1]), 32'h0000_0015);
    apb(1'b1, OFS_STATUS, 32'h0000_0020);
    apb(1'b0, OFS_STATUS, '0);
    chk(32'(rd[5]), 32'h0000_0000);
    fld(4'h3, 12'h0000, 12'h0FFF);
    chk(32'({backup_fail, run_cmd}), 32'h0000_0002);
    fld(4'h3);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    apb(1'b0, OFS_CTRL, '0);
    chk(rd, 32'h0000_0000);
    // enable low must freeze the run decision while contact b opens
    ce <= 1'b0;
    fld(4'h1);
    chk(32'(run_cmd), 32'h0000_0001);
    ce <= 1'b1;
    settle();
    chk(32'(run_cmd), 32'h0000_0000);
    scheme(SCH_SWAP);
    for (int c = 0; c < 2; c++) begin
      fld(4'(3 + 4 * c));
      chk(32'(feedback_src), 32'(c));
    end
    fld(4'h3, 12'h0000);
    chk(32'(feedback_src), 32'(SRC_BACKUP));
    close_out();
  end
endmodule : tb
